// [core/fsd_status.sv]
// fieldbus status lamps, internal link fault and diagnostic record
`timescale 1ns/1ps
`include "fsd_consts.svh"
// How it works
// - module lamp off unpowered, red on link fault, green when operational
// - module lamp flickers red on bad config or controller stop; comm loss latches link fault, steady red
// - module lamp single red flash when controller not connected
// - green flicker on identify; both lamps green/red during power-up test
// - network lamp off without IP, red on module error, green when up
// - network lamp flickers green until parameter backup client finishes
// - network lamp three green flashes: ports unplugged, IP held
// - network lamp four green flashes on duplicate IP
// - network lamp five green flashes during DHCP
// - port lamp off no link, green 100M, yellow 10M
// - port lamp blinks its speed colour during traffic
// - Modbus TCP only mode uses an alternative scheme on both lamps
// - link fault raised on module hardware error or drive comm loss
// - link fault always forces a freewheel stop
// - link fault latched until power cycle
// - detail codes 0..7 for none, comm, hardware and memory faults
// - detail codes 101, 102, 103 for unknown, bus break, 500 ms timeout
// - event report captures fault code, state word, output speed
// - record byte 29 holds length 6
// - byte 30 is fault code low byte when state bit 3 set
// - bytes 31..34 hold state word then speed, low byte first
module fsd_status #(
  parameter int BUS_TMO_CYC = `FSD_BUS_TMO_CYC, // internal bus silence
  parameter int TICK_CYC    = `FSD_TICK_CYC     // pattern tick
) (
  input  wire logic        clk_in,          // module clock
  input  wire logic        rst_in,          // power-on reset
  input  wire logic        selftest_in,     // power-up test running
  input  wire logic        identify_in,     // dcp identify / flash mode
  input  wire logic        comm_interrupt_in, // comm interruption
  input  wire logic        bad_config_in,   // wrong configuration
  input  wire logic        ctrl_stop_in,    // controller in stop
  input  wire logic        ctrl_conn_in,    // controller connected
  input  wire logic        modbus_only_in,  // modbus tcp server only
  input  wire logic        ip_valid_in,     // ip address held
  input  wire logic        module_err_in,   // module error
  input  wire logic        backup_busy_in,  // backup client transferring
  input  wire logic        dup_ip_in,       // duplicate ip seen
  input  wire logic        dhcp_busy_in,    // dhcp running
  input  wire logic [1:0]  port_link_in,    // link up per port
  input  wire logic [1:0]  port_fast_in,    // 100M link per port
  input  wire logic [1:0]  port_act_in,     // traffic per port
  input  wire logic        hw_err_in,       // module hardware error
  input  wire logic [2:0]  mem_fault_in,    // 0 none, 3..7 memory codes
  input  wire logic        unknown_mod_in,  // unknown module
  input  wire logic        bus_break_in,    // internal bus interrupted
  input  wire logic        bus_resp_in,     // internal bus response
  input  wire logic        diag_event_in,   // capture diagnostic record
  input  wire logic [15:0] state_word_in,   // operating state word
  input  wire logic [15:0] fault_code_in,   // last fault code
  input  wire logic [15:0] out_speed_in,    // output speed
  output logic [1:0]       module_status_lamp_out,  // colour
  output logic [1:0]       network_status_lamp_out, // colour
  output logic [1:0]       port_a_link_lamp_out,    // colour
  output logic [1:0]       port_b_link_lamp_out,    // colour
  output logic             internal_link_fault_out, // latched fault
  output logic             freewheel_stop_out,      // coast the motor
  output logic [7:0]       slot_a_link_detail_code_out, // cause
  output logic [47:0]      diag_record_out, // bytes 29..34, 29 in low
  output logic             diag_valid_out   // record captured
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        fault;
    logic [7:0]  code;
    logic [31:0] tmo;
    logic [47:0] rec;
    logic        rec_v;
  } fsd_st_t;
  fsd_st_t s_ff, nxt_s;

  logic              flick_w;
  logic              blink_w;
  logic [4:0]        slot_w;
  fsd_pkg::fsd_pat_t mod_pat;
  fsd_pkg::fsd_pat_t net_pat;
  logic [1:0]        mod_col;
  logic [1:0]        net_col;
  logic [2:0]        net_cnt;
  fsd_pkg::fsd_pat_t port_pat [2];
  logic [1:0]        port_col [2];
  logic [1:0]        lamp_w   [4];
  logic              tmo_hit;
  logic [7:0]        cause;

  // ****************************************************************
  // timebase
  // ****************************************************************
  fsd_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .flick_out (flick_w),
    .blink_out (blink_w),
    .slot_out  (slot_w)
  );

  // ****************************************************************
  // lamp pattern selection
  // ****************************************************************
  always_comb begin
    mod_pat = fsd_pkg::FSD_PAT_OFF;
    mod_col = `FSD_LAMP_OFF;
    if (selftest_in) begin
      mod_pat = fsd_pkg::FSD_PAT_BLINK;
      mod_col = `FSD_LAMP_GREEN;
    end else if (s_ff.fault) begin
      mod_pat = fsd_pkg::FSD_PAT_ON;
      mod_col = `FSD_LAMP_RED;
    end else if (modbus_only_in) begin
      // alternative scheme: steady green; comm loss latches the link fault, so steady red
      mod_pat = comm_interrupt_in ? fsd_pkg::FSD_PAT_FLICKER
                                  : fsd_pkg::FSD_PAT_ON;
      mod_col = comm_interrupt_in ? `FSD_LAMP_RED : `FSD_LAMP_GREEN;
    end else if (identify_in) begin
      mod_pat = fsd_pkg::FSD_PAT_FLICKER;
      mod_col = `FSD_LAMP_GREEN;
    end else if (comm_interrupt_in || bad_config_in || ctrl_stop_in) begin
      mod_pat = fsd_pkg::FSD_PAT_FLICKER;
      mod_col = `FSD_LAMP_RED;
    end else if (!ctrl_conn_in) begin
      mod_pat = fsd_pkg::FSD_PAT_SINGLE;
      mod_col = `FSD_LAMP_RED;
    end else begin
      mod_pat = fsd_pkg::FSD_PAT_ON;
      mod_col = `FSD_LAMP_GREEN;
    end
  end

  always_comb begin
    net_pat = fsd_pkg::FSD_PAT_OFF;
    net_col = `FSD_LAMP_GREEN;
    net_cnt = 3'h0;
    if (selftest_in) begin
      net_pat = fsd_pkg::FSD_PAT_BLINK;
    end else if (module_err_in || s_ff.fault) begin
      net_pat = fsd_pkg::FSD_PAT_ON;
      net_col = `FSD_LAMP_RED;
    end else if (modbus_only_in) begin
      // alternative scheme: steady green with ip, else off
      net_pat = ip_valid_in ? fsd_pkg::FSD_PAT_ON
                            : fsd_pkg::FSD_PAT_OFF;
    end else if (dup_ip_in) begin
      net_pat = fsd_pkg::FSD_PAT_BURST;
      net_cnt = 3'h4;
    end else if (identify_in || backup_busy_in) begin
      net_pat = fsd_pkg::FSD_PAT_FLICKER;
    end else if (dhcp_busy_in) begin
      net_pat = fsd_pkg::FSD_PAT_BURST;
      net_cnt = 3'h5;
    end else if (!ip_valid_in) begin
      net_pat = fsd_pkg::FSD_PAT_OFF;
    end else if (port_link_in == 2'h0) begin
      net_pat = fsd_pkg::FSD_PAT_BURST;
      net_cnt = 3'h3;
    end else begin
      net_pat = fsd_pkg::FSD_PAT_ON;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      port_col[i] = port_fast_in[i] ? `FSD_LAMP_GREEN
                                    : `FSD_LAMP_YELLOW;
      if (!port_link_in[i]) begin
        port_pat[i] = fsd_pkg::FSD_PAT_OFF;
      end else if (port_act_in[i]) begin
        port_pat[i] = fsd_pkg::FSD_PAT_FLICKER;
      end else begin
        port_pat[i] = fsd_pkg::FSD_PAT_ON;
      end
    end
  end

  // ****************************************************************
  // lamp drivers
  // ****************************************************************
  fsd_lamp u_mod (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pat_in   (mod_pat),
    .col_in   (mod_col),
    .alt_in   (`FSD_LAMP_RED),
    .count_in (3'h0),
    .flick_in (flick_w),
    .blink_in (blink_w),
    .slot_in  (slot_w),
    .lamp_out (lamp_w[0])
  );

  fsd_lamp u_net (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pat_in   (net_pat),
    .col_in   (net_col),
    .alt_in   (`FSD_LAMP_RED),
    .count_in (net_cnt),
    .flick_in (flick_w),
    .blink_in (!blink_w),
    .slot_in  (slot_w),
    .lamp_out (lamp_w[1])
  );

  for (genvar g = 0; g < 2; g++) begin : g_port
    fsd_lamp u_port (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .pat_in   (port_pat[g]),
      .col_in   (port_col[g]),
      .alt_in   (`FSD_LAMP_OFF),
      .count_in (3'h0),
      .flick_in (blink_w),
      .blink_in (blink_w),
      .slot_in  (slot_w),
      .lamp_out (lamp_w[2 + g])
    );
  end

  assign module_status_lamp_out  = lamp_w[0];
  assign network_status_lamp_out = lamp_w[1];
  assign port_a_link_lamp_out    = lamp_w[2];
  assign port_b_link_lamp_out    = lamp_w[3];

  // ****************************************************************
  // internal link fault and detail code
  // ****************************************************************
  assign tmo_hit = (s_ff.tmo >= 32'(BUS_TMO_CYC - 1));

  always_comb begin
    cause = `FSD_DC_NONE;
    if (hw_err_in) begin
      cause = `FSD_DC_HW;
    end else if (mem_fault_in >= 3'h3) begin
      cause = {5'h00, mem_fault_in};
    end else if (unknown_mod_in) begin
      cause = `FSD_DC_UNKNOWN;
    end else if (bus_break_in) begin
      cause = `FSD_DC_BUS_INT;
    end else if (tmo_hit) begin
      cause = `FSD_DC_BUS_TMO;
    end else if (comm_interrupt_in) begin
      cause = `FSD_DC_COMM;
    end
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tmo = (bus_resp_in || tmo_hit) ? 32'h0 : s_ff.tmo + 32'h1;
    // first cause is kept; only a power-on reset clears it
    if (!s_ff.fault && cause != `FSD_DC_NONE) begin
      nxt_s.fault = 1'b1;
      nxt_s.code  = cause;
    end
    if (diag_event_in) begin
      nxt_s.rec_v = 1'b1;
      nxt_s.rec = {out_speed_in, state_word_in,
                   state_word_in[`FSD_ETA_FAULT_BIT]
                     ? fault_code_in[7:0] : 8'h00,
                   `FSD_EXT_LEN};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign internal_link_fault_out     = s_ff.fault;
  assign freewheel_stop_out          = s_ff.fault;
  assign slot_a_link_detail_code_out = s_ff.code;
  assign diag_record_out             = s_ff.rec;
  assign diag_valid_out              = s_ff.rec_v;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence hw_seen_s;
    !s_ff.fault && hw_err_in;
  endsequence

  fault_raise_a: assert property (
    hw_seen_s |=> internal_link_fault_out &&
    slot_a_link_detail_code_out == `FSD_DC_HW)
    else $error("hardware error not latched");
  fault_hold_a: assert property (
    internal_link_fault_out |=> internal_link_fault_out &&
    $stable(slot_a_link_detail_code_out))
    else $error("link fault released");
  coast_tie_a: assert property (
    internal_link_fault_out == freewheel_stop_out)
    else $error("no freewheel on link fault");
  bus_tmo_a: assert property (
    !s_ff.fault && tmo_hit && !hw_err_in && mem_fault_in < 3'h3 &&
    !unknown_mod_in && !bus_break_in
    |=> slot_a_link_detail_code_out == `FSD_DC_BUS_TMO)
    else $error("bus timeout code wrong");
  rec_len_a: assert property (
    diag_valid_out |-> diag_record_out[7:0] == `FSD_EXT_LEN)
    else $error("record length not 6");
  rec_fault_a: assert property (
    diag_event_in && !state_word_in[`FSD_ETA_FAULT_BIT]
    |=> diag_record_out[15:8] == 8'h00)
    else $error("fault byte not zero");
  rec_code_a: assert property (
    diag_event_in && state_word_in[`FSD_ETA_FAULT_BIT] |=>
    diag_record_out[15:8] == $past(fault_code_in[7:0]))
    else $error("fault byte wrong");
  rec_words_a: assert property (
    diag_event_in |=>
    diag_record_out[47:16] == $past({out_speed_in, state_word_in}))
    else $error("record words wrong");
  mod_red_a: assert property (
    !selftest_in && s_ff.fault |=> module_status_lamp_out == `FSD_LAMP_RED)
    else $error("module lamp not red");
  test_pair_a: assert property (
    selftest_in |=> module_status_lamp_out != network_status_lamp_out &&
    module_status_lamp_out != `FSD_LAMP_OFF)
    else $error("test lamps not opposite");
  net_noip_a: assert property (
    !selftest_in && !module_err_in && !s_ff.fault && !modbus_only_in &&
    !dup_ip_in && !identify_in && !backup_busy_in && !dhcp_busy_in &&
    !ip_valid_in |=> network_status_lamp_out == `FSD_LAMP_OFF)
    else $error("network lamp lit without ip");
  net_red_a: assert property (
    !selftest_in && module_err_in |=>
    network_status_lamp_out == `FSD_LAMP_RED)
    else $error("network lamp not red on error");
  port_off_a: assert property (
    !port_link_in[0] |=> port_a_link_lamp_out == `FSD_LAMP_OFF)
    else $error("port lamp lit without link");
  port_fast_a: assert property (
    port_link_in[0] && port_fast_in[0] && !port_act_in[0] |=>
    port_a_link_lamp_out == `FSD_LAMP_GREEN)
    else $error("fast link lamp not green");
  port_slow_a: assert property (
    port_link_in[1] && !port_fast_in[1] && !port_act_in[1] |=>
    port_b_link_lamp_out == `FSD_LAMP_YELLOW)
    else $error("slow link lamp not yellow");
endmodule

// [core/fsd_consts.svh]
// constants for the fieldbus status and diagnostics block
`ifndef FSD_CONSTS_SVH
`define FSD_CONSTS_SVH

// timebase: one tick every 50 ms at 250 MHz
`define FSD_CLK_MHZ        250
`define FSD_TICK_MS        50
`define FSD_TICK_CYC       (`FSD_TICK_MS * 1000 * `FSD_CLK_MHZ)
// internal bus silence limit
`define FSD_BUS_TMO_MS     500
`define FSD_BUS_TMO_CYC    (`FSD_BUS_TMO_MS * 1000 * `FSD_CLK_MHZ)

// lamp colours
`define FSD_LAMP_OFF       2'h0
`define FSD_LAMP_GREEN     2'h1
`define FSD_LAMP_RED       2'h2
`define FSD_LAMP_YELLOW    2'h3

// detail codes
`define FSD_DC_NONE        8'h00
`define FSD_DC_COMM        8'h01
`define FSD_DC_HW          8'h02
`define FSD_DC_EE_CSUM     8'h03
`define FSD_DC_EEPROM      8'h04
`define FSD_DC_FLASH       8'h05
`define FSD_DC_RAM         8'h06
`define FSD_DC_NVRAM       8'h07
`define FSD_DC_UNKNOWN     8'h65
`define FSD_DC_BUS_INT     8'h66
`define FSD_DC_BUS_TMO     8'h67

// diagnostic record
`define FSD_EXT_LEN        8'h06
`define FSD_ETA_FAULT_BIT  3

`endif

// [core/fsd_pkg.sv]
// types for the fieldbus status and diagnostics block
package fsd_pkg;
  typedef enum logic [2:0] {
    FSD_PAT_OFF,
    FSD_PAT_ON,
    FSD_PAT_FLICKER,
    FSD_PAT_BLINK,
    FSD_PAT_SINGLE,
    FSD_PAT_BURST
  } fsd_pat_t;
endpackage

// [core/fsd_timebase.sv]
// shared timebase giving phases for all lamp patterns
`timescale 1ns/1ps
`include "fsd_consts.svh"
module fsd_timebase #(
  parameter int TICK_CYC = `FSD_TICK_CYC
) (
  input  wire logic       clk_in,    // module clock
  input  wire logic       rst_in,    // sync reset
  output logic            flick_out, // fast toggle, every tick
  output logic            blink_out, // slow toggle, every 4 ticks
  output logic [4:0]      slot_out   // 32-slot frame position, 4 ticks per slot
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [6:0]  ph;
  } fsd_tb_t;
  fsd_tb_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (s_ff.cnt >= 32'(TICK_CYC - 1)) begin
      nxt_s.cnt = 32'h0;
      nxt_s.ph  = s_ff.ph + 7'h01;
    end else begin
      nxt_s.cnt = s_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign flick_out = s_ff.ph[0];
  assign blink_out = s_ff.ph[2];
  assign slot_out  = s_ff.ph[6:2];

  tick_wrap_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_ff.cnt == 32'(TICK_CYC - 1) |=> s_ff.cnt == 32'h0)
    else $error("timebase did not wrap");
endmodule

// [core/fsd_lamp.sv]
// one lamp: turns a pattern and colour into a driven colour
`timescale 1ns/1ps
`include "fsd_consts.svh"
module fsd_lamp (
  input  wire logic          clk_in,    // module clock
  input  wire logic          rst_in,    // sync reset
  input  fsd_pkg::fsd_pat_t  pat_in,    // pattern
  input  wire logic [1:0]    col_in,    // main colour
  input  wire logic [1:0]    alt_in,    // blink alternate colour
  input  wire logic [2:0]    count_in,  // flashes per burst
  input  wire logic          flick_in,  // fast phase
  input  wire logic          blink_in,  // slow phase
  input  wire logic [4:0]    slot_in,   // frame slot
  output logic [1:0]         lamp_out   // colour shown
);
  typedef struct packed {
    logic [1:0] lamp;
  } fsd_lp_t;
  fsd_lp_t s_ff, nxt_s;
  logic on_w;

  always_comb begin
    nxt_s = s_ff;
    on_w = 1'b0;
    unique case (pat_in)
      fsd_pkg::FSD_PAT_OFF:     on_w = 1'b0;
      fsd_pkg::FSD_PAT_ON:      on_w = 1'b1;
      fsd_pkg::FSD_PAT_FLICKER: on_w = flick_in;
      fsd_pkg::FSD_PAT_BLINK:   on_w = 1'b1;
      fsd_pkg::FSD_PAT_SINGLE:  on_w = (slot_in[2:0] == 3'h0);
      // flash on even slots, then a gap to the end of the frame
      fsd_pkg::FSD_PAT_BURST: on_w = !slot_in[0] &&
                              (slot_in[4:1] < {1'b0, count_in});
      default:                  on_w = 1'b0;
    endcase
    if (pat_in == fsd_pkg::FSD_PAT_BLINK) begin
      nxt_s.lamp = blink_in ? alt_in : col_in;
    end else begin
      nxt_s.lamp = on_w ? col_in : `FSD_LAMP_OFF;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lamp_out = s_ff.lamp;

  off_dark_a: assert property (@(posedge clk_in) disable iff (rst_in)
    pat_in == fsd_pkg::FSD_PAT_OFF |=> lamp_out == `FSD_LAMP_OFF)
    else $error("lamp lit while off");
endmodule

// [testbench/fsd_core_model.sv]
// drive core model answering the block's internal bus
`timescale 1ns/1ps
module fsd_core_model (
  input  wire logic       clk_in,   // module clock
  input  wire logic       rst_in,   // sync reset
  input  wire logic [1:0] mode_in,  // 0 prompt, 1 slow, 2 silent
  output logic            resp_out  // one-cycle response pulse
);
  // ****************
  // answer pacing
  // ****************
  // slow gap is 16 cycles, just inside the shortened silence limit
  int gap_ff;
  int lim;
  assign lim = (mode_in == 2'h0) ? 3 : 15;
  always_ff @(posedge clk_in) begin
    if (rst_in || gap_ff >= lim) begin
      gap_ff <= 0;
    end else begin
      gap_ff <= gap_ff + 1;
    end
    resp_out <= !rst_in && mode_in != 2'h2 && gap_ff == lim;
  end
endmodule

// [testbench/fsd_status_tb.sv]
// self-checking bench for the fieldbus status and diagnostics block
`timescale 1ns/1ps
`include "fsd_consts.svh"
module fsd_status_tb;
  // ****************
  // signals and parts
  // ****************
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        selftest, identify, comm_int, bad_cfg, ctrl_stop, ctrl_conn;
  logic        modbus, ip_ok, mod_err, backup, dup_ip, dhcp, hw_err;
  logic        unk_mod, bus_brk, diag_ev, resp, flt, stop, dvalid;
  logic [1:0]  link, fast, act, core_mode, mod_l, net_l, pa_l, pb_l;
  logic [2:0]  mem_f;
  logic [7:0]  code;
  logic [15:0] state_w, fault_c, speed;
  logic [47:0] rec;
  logic [7:0]  exp_c [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                              8'h07, 8'h65, 8'h66, 8'h01, 8'h67};
  int          fail_count = 0;
  int          n_tests = 0;

  always #2 clk_in = ~clk_in;

  // short counts keep the run brief; expectations follow them
  fsd_status #(.BUS_TMO_CYC(20), .TICK_CYC(4)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .selftest_in(selftest),
    .identify_in(identify), .comm_interrupt_in(comm_int),
    .bad_config_in(bad_cfg), .ctrl_stop_in(ctrl_stop),
    .ctrl_conn_in(ctrl_conn), .modbus_only_in(modbus),
    .ip_valid_in(ip_ok), .module_err_in(mod_err),
    .backup_busy_in(backup), .dup_ip_in(dup_ip), .dhcp_busy_in(dhcp),
    .port_link_in(link), .port_fast_in(fast), .port_act_in(act),
    .hw_err_in(hw_err), .mem_fault_in(mem_f), .unknown_mod_in(unk_mod),
    .bus_break_in(bus_brk), .bus_resp_in(resp), .diag_event_in(diag_ev),
    .state_word_in(state_w), .fault_code_in(fault_c),
    .out_speed_in(speed), .module_status_lamp_out(mod_l),
    .network_status_lamp_out(net_l), .port_a_link_lamp_out(pa_l),
    .port_b_link_lamp_out(pb_l), .internal_link_fault_out(flt),
    .freewheel_stop_out(stop), .slot_a_link_detail_code_out(code),
    .diag_record_out(rec), .diag_valid_out(dvalid));

  fsd_core_model core (.clk_in(clk_in), .rst_in(rst_in),
                       .mode_in(core_mode), .resp_out(resp));

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  function automatic logic [1:0] lamp(input int sel);
    case (sel)
      0: lamp = mod_l;
      1: lamp = net_l;
      2: lamp = pa_l;
      default: lamp = pb_l;
    endcase
  endfunction

  // colours seen as a mask (bit per colour) and count of off-to-lit edges;
  // edges are counted from the colour shown as the window opens, so the window phase can matter
  task automatic watch(input int n, input int sel, output logic [3:0] s,
                       output int r);
    logic [1:0] c, p;
    s = 4'h0;
    r = 0;
    p = lamp(sel);
    repeat (n) begin
      step(1);
      c = lamp(sel);
      s[c] = 1'b1;
      if (c != 2'h0 && p == 2'h0) r++;
      p = c;
    end
  endtask

  task automatic do_reset();
    rst_in = 1'b1;
    {selftest, identify, comm_int, bad_cfg, ctrl_stop, modbus} = '0;
    {mod_err, backup, dup_ip, dhcp, hw_err, unk_mod, bus_brk} = '0;
    {diag_ev, mem_f, act, core_mode, state_w, fault_c, speed} = '0;
    {ctrl_conn, ip_ok, link, fast} = '1;
    step(6);
    chk("reset lamps", 48'h0, {40'h0, mod_l, net_l, pa_l, pb_l});
    chk("reset flags", 48'h0, {37'h0, flt, stop, dvalid, code});
    rst_in = 1'b0;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_normal();
    logic [3:0] s;
    int r;
    do_reset();
    core_mode = 2'h1;
    step(4);
    watch(100, 0, s, r);
    chk("module ready", 48'h2, 48'(s));
    watch(40, 1, s, r);
    chk("network up", 48'h2, 48'(s));
    chk("no fault", 48'h0, {39'h0, flt, code});
    $display("test normal done");
  endtask

  task automatic t_selftest();
    logic [3:0] s;
    int r;
    int bad;
    do_reset();
    {selftest, mod_err, bad_cfg} = 3'h7;
    step(4);
    bad = 0;
    repeat (64) begin
      step(1);
      if (net_l !== (mod_l == `FSD_LAMP_GREEN ? `FSD_LAMP_RED
                                              : `FSD_LAMP_GREEN)) bad++;
    end
    chk("network opposite", 48'h0, 48'(bad));
    watch(64, 0, s, r);
    chk("selftest colours", 48'h6, 48'(s));
    $display("test selftest done");
  endtask

  task automatic t_module();
    logic [3:0] s;
    int r;
    for (int k = 0; k < 3; k++) begin
      do_reset();
      case (k)
        0: bad_cfg = 1'b1;
        1: ctrl_stop = 1'b1;
        default: identify = 1'b1;
      endcase
      step(4);
      watch(32, 0, s, r);
      chk("module flicker", k == 2 ? 48'h3 : 48'h5, 48'(s));
      chk("flicker edges", 48'h4, 48'(r));
    end
    do_reset();
    ctrl_conn = 1'b0;
    step(4);
    watch(128, 0, s, r);
    chk("single flash", 48'h5, 48'(s));
    chk("single edges", 48'h1, 48'(r));
    $display("test module lamp done");
  endtask

  task automatic t_network();
    logic [3:0] s;
    int r;
    for (int k = 0; k < 4; k++) begin
      do_reset();
      case (k)
        0: link = 2'h0;
        1: dup_ip = 1'b1;
        2: dhcp = 1'b1;
        default: backup = 1'b1;
      endcase
      step(4);
      // a burst frame is 32 slots of 16 cycles with these counts
      watch(k == 3 ? 32 : 512, 1, s, r);
      chk("network green flash", 48'h3, 48'(s));
      chk("flash count", k == 3 ? 48'h4 : 48'(k + 3),
          48'(r));
    end
    {ip_ok, backup} = 2'h0;
    step(4);
    watch(32, 1, s, r);
    chk("network no ip", 48'h1, 48'(s));
    {ip_ok, mod_err} = 2'h3;
    step(4);
    watch(32, 1, s, r);
    chk("network error", 48'h4, 48'(s));
    {mod_err, modbus, dup_ip, link, bad_cfg} = 6'h1f;
    step(4);
    watch(32, 1, s, r);
    chk("modbus network", 48'h2, 48'(s));
    watch(32, 0, s, r);
    chk("modbus module", 48'h2, 48'(s));
    $display("test network lamp done");
  endtask

  task automatic t_ports();
    logic [3:0] s;
    int r;
    do_reset();
    {fast, act} = 4'h5;
    step(4);
    watch(64, 2, s, r);
    chk("port a activity", 48'h3, 48'(s));
    chk("blink edges", 48'h2, 48'(r));
    watch(64, 3, s, r);
    chk("port b slow link", 48'h8, 48'(s));
    {link, act} = 4'ha;
    step(4);
    watch(64, 3, s, r);
    chk("port b activity", 48'h9, 48'(s));
    watch(16, 2, s, r);
    chk("port a no link", 48'h1, 48'(s));
    $display("test ports done");
  endtask

  task automatic t_faults();
    logic [3:0] s;
    int r;
    int w;
    for (int i = 0; i < 10; i++) begin
      do_reset();
      case (i)
        0: hw_err = 1'b1;
        1, 2, 3, 4, 5: mem_f = 3'(i + 2);
        6: unk_mod = 1'b1;
        7: bus_brk = 1'b1;
        8: comm_int = 1'b1;
        default: core_mode = 2'h2;
      endcase
      if (i == 9) begin
        for (w = 0; w < 40 && flt !== 1'b1; w++) step(1);
        chk("timeout span", 48'h14, 48'(w));
      end else begin
        step(1);
      end
      chk("fault raised", {38'h0, 2'h3, exp_c[i]},
          {38'h0, flt, stop, code});
      {hw_err, unk_mod, bus_brk, comm_int, mem_f, core_mode} = '0;
      if (i == 0) bus_brk = 1'b1;
      else hw_err = 1'b1;
      step(4);
      watch(16, 0, s, r);
      chk("fault lamp", 48'h4, 48'(s));
      chk("fault latched", {38'h0, 2'h3, exp_c[i]},
          {38'h0, flt, stop, code});
    end
    $display("test faults done");
  endtask

  task automatic t_diag();
    do_reset();
    {state_w, fault_c, speed} = {16'h1238, 16'h5aa7, 16'hbe0f};
    diag_ev = 1'b1;
    step(1);
    chk("record fault", {16'hbe0f, 16'h1238, 16'ha706},
        rec);
    {state_w, speed} = {16'h0f07, 16'h0102};
    step(1);
    chk("record no fault", {16'h0102, 16'h0f07, 16'h0006}, rec);
    diag_ev = 1'b0;
    state_w = 16'hffff;
    step(3);
    chk("record held", {16'h0102, 16'h0f07, 16'h0006}, rec);
    chk("record valid", 48'h1, 48'(dvalid));
    $display("test diag done");
  endtask

  // ****************
  // run and verdict
  // ****************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    t_normal();
    t_selftest();
    t_module();
    t_network();
    t_ports();
    t_faults();
    t_diag();
    test_done();
  end

  // the tests take about 2800 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    test_done();
  end
endmodule
